/* testbench/single_wire_id_slot_timing_bench.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module single_wire_id_slot_timing_bench;
    localparam logic [63:0] ROM_ID = 64'h3C5A_7E12_3456_78A6;
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic rd_ready = 1'b0, present = 1'b1;
    wire cmd_ready, busy, presence, presence_done, rd_valid, crc_ok;
    wire line_out, line_oe, pull_low;
    wire [7:0] rd_data, crc;
    wire line = (line_oe ? line_out : 1'b1) && !pull_low;
    int err_count = 0, comparisons = 0;
    swid_master #(.RESET_LOW_CYC(20'h00FA0), .RESET_HIGH_CYC(20'h00190),
        .PRESENCE_CYC(20'h00096), .SLOT_CYC(20'h00E10),
        .LOW0_CYC(20'h00190)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .busy(busy), .presence(presence),
        .presence_done(presence_done), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .crc(crc),
        .crc_ok(crc_ok), .line_in(line), .line_out(line_out),
        .line_oe(line_oe));
    swid_slave_model #(.ROM_ID(ROM_ID)) far (.clk(clk), .present(present),
        .line(line), .pull_low(pull_low));
    // Clock, 4 ns period
    always #2 clk = ~clk;
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] crc_of(input logic [7:0] b);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        return c;
    endfunction
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge clk);
        #1;
        while (cmd_ready !== 1'b1 && k < 40000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("cmd_ready", {7'h00, cmd_ready}, 8'h01);
    endtask
    task automatic issue(input logic [1:0] op, input logic [7:0] data);
        wait_ready();
        @(posedge clk);
        cmd_op <= op;
        cmd_data <= data;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic t_reset(input logic exp);
        issue(2'h0, 8'h00);
        wait_ready();
        check("presence", {7'h00, presence}, {7'h00, exp});
        $display("reset test done");
    endtask
    task automatic t_write;
        issue(2'h1, 8'h33);
        repeat (1000) @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        wait_ready();
        check("written byte", far.cmd_rx, 8'h33);
        $display("write test done");
    endtask
    task automatic t_read;
        issue(2'h2, 8'h00);
        wait_ready();
        repeat (4) @(posedge clk);
        #1;
        check("read valid", {7'h00, rd_valid}, 8'h01);
        check("read byte", rd_data, ROM_ID[7:0]);
        check("crc", crc, crc_of(ROM_ID[7:0]));
        check("crc ok", {7'h00, crc_ok},
              {7'h00, crc_of(ROM_ID[7:0]) == 8'h00});
        @(posedge clk);
        rd_ready <= 1'b1;
        @(posedge clk);
        rd_ready <= 1'b0;
        #1;
        check("read taken", {7'h00, rd_valid}, 8'h00);
        $display("read test done");
    endtask
    task automatic t_crc_clear;
        issue(2'h3, 8'h00);
        wait_ready();
        check("crc cleared", crc, 8'h00);
        check("crc ok cleared", {7'h00, crc_ok}, 8'h01);
        $display("crc clear test done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset(1'b1);
        t_write();
        t_read();
        t_crc_clear();
        present <= 1'b0;
        t_reset(1'b0);
        wrap_up();
    end
    // Watchdog, well past two bytes and two resets
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule // single_wire_id_slot_timing_bench
`default_nettype wire

/* testbench/swid_master_sva.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module swid_master_sva #(
    parameter [19:0] RESET_LOW_CYC  = 20'h1D4C0,
    parameter [19:0] RESET_HIGH_CYC = 20'h1D4C0,
    parameter [19:0] LOW0_CYC       = 20'h03A98
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       ce,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic       busy,
    input wire logic       presence_done,
    input wire logic [7:0] crc,
    input wire logic       line_out,
    input wire logic       line_oe
);
    localparam [19:0] ONE_US = 20'h000FA;
    logic [19:0] oe_cnt;
    logic [19:0] hi_cnt;
    logic        rst_pulse;
    wire         acc = ce && cmd_valid && cmd_ready;
    // Lengths of driven and released spans
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_cnt    <= 20'h00000;
            hi_cnt    <= 20'hFFFFF;
            rst_pulse <= 1'b0;
        end else if (ce) begin
            oe_cnt <= line_oe ? oe_cnt + 20'h00001 : 20'h00000;
            if (line_oe)
                hi_cnt <= 20'h00000;
            else if (hi_cnt != 20'hFFFFF)
                hi_cnt <= hi_cnt + 20'h00001;
            if (!line_oe && oe_cnt != 20'h00000)
                rst_pulse <= (oe_cnt == RESET_LOW_CYC);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    pulse_len_a: assert property ($fell(line_oe) |->
        oe_cnt == ONE_US || oe_cnt == LOW0_CYC || oe_cnt == RESET_LOW_CYC)
        else $error("low pulse length wrong");
    low_limit_a: assert property (oe_cnt <= RESET_LOW_CYC)
        else $error("line held low too long");
    recovery_gap_a: assert property ($rose(line_oe) |-> hi_cnt >= ONE_US)
        else $error("recovery gap too short");
    reset_gap_a: assert property ($rose(line_oe) && rst_pulse |->
        hi_cnt >= RESET_HIGH_CYC) else $error("reset high time too short");
    slot_open_a: assert property (acc && cmd_op != 2'h3 |=>
        busy && line_oe && !cmd_ready) else $error("operation did not start");
    crc_clear_a: assert property (acc && cmd_op == 2'h3 |=>
        crc == 8'h00 && !busy) else $error("crc not cleared");
    idle_release_a: assert property (!busy |-> !line_oe)
        else $error("line driven while idle");
    drive_low_a: assert property (line_oe |-> line_out == 1'b0)
        else $error("line driven high");
    freeze_hold_a: assert property (!ce |=> $stable(line_oe) && $stable(busy))
        else $error("state moved while disabled");
    done_pulse_a: assert property (presence_done |=>
        !presence_done && !busy) else $error("presence done not a pulse");
    cover property ($fell(line_oe) && oe_cnt == RESET_LOW_CYC);
    cover property ($fell(line_oe) && oe_cnt == LOW0_CYC);
    cover property (acc && cmd_op == 2'h2);
endmodule // swid_master_sva

bind swid_master swid_master_sva #(.RESET_LOW_CYC(RESET_LOW_CYC),
    .RESET_HIGH_CYC(RESET_HIGH_CYC), .LOW0_CYC(LOW0_CYC)) chk (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .busy(busy),
    .presence_done(presence_done), .crc(crc), .line_out(line_out),
    .line_oe(line_oe));
`default_nettype wire

/* testbench/swid_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module swid_slave_model #(
    parameter int          RST_MIN = 2000,
    parameter int          PDH     = 60,
    parameter int          PDL     = 200,
    parameter int          WSAMP   = 300,
    parameter int          RDV     = 3750,
    // Arbitrary identity; bits 55:44 play the customer field
    parameter logic [63:0] ROM_ID  = 64'h3C5A_7E12_3456_78A6
) (
    input  wire logic clk,
    input  wire logic present,
    input  wire logic line,
    output wire logic pull_low
);
    logic       drive;
    logic       smp;
    logic [7:0] cmd_rx;
    int         n;
    int         bitn;
    assign pull_low = drive && present;
    // Slots are timed from each falling edge of the line
    initial begin
        drive <= 1'b0;
        bitn = 0;
        cmd_rx = 8'h00;
        forever begin
            @(negedge line);
            n = (bitn >= 8) ? RDV : WSAMP;
            drive <= (bitn >= 8 && bitn < 72) ? !ROM_ID[bitn-8] : 1'b0;
            repeat (n) @(posedge clk);
            smp = line;
            drive <= 1'b0;
            #1;
            // Only a master still holding low after our release is a reset
            if (line)
                n = 0;
            while (!line) begin
                @(posedge clk);
                n++;
            end
            if (n >= RST_MIN) begin
                repeat (PDH) @(posedge clk);
                drive <= 1'b1;
                repeat (PDL) @(posedge clk);
                drive <= 1'b0;
                bitn = 0;
            end else begin
                if (bitn < 8)
                    cmd_rx = {smp, cmd_rx[7:1]};
                bitn++;
            end
        end
    end
endmodule // swid_slave_model
`default_nettype wire

/* verilog/swid_master.v */
`timescale 1ns/1ps
`default_nettype none
`include "swid_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Read-data buffer
module swid_fifo #(
    parameter W  = `SWID_FIFO_WIDTH,
    parameter D  = `SWID_FIFO_DEPTH,
    parameter AW = `SWID_FIFO_ADDR
) (
    input  wire          clk,
    input  wire          sys_rst,
    input  wire          ce,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [AW:0]   count;
    wire          push;
    wire          pop;

    // Honest flags from the fill count
    assign in_ready  = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // Storage, no reset needed
    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers and count
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // swid_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// - The ID check byte is the CRC with polynomial x^8 + x^5 + x^4 + 1.
// - The master runs the CRC over received bits and a match is error-free.
// - Reset low time plus line rise time stays under 960 us.
// - The reset pulse holds the line low at least 480 us and under 960 us.
// - After a reset the line stays high at least 480 us before more traffic.
// - Every slot opens with the master low; the slave holds low to send zero.
// - The master samples a read bit late but inside the 15 us valid window.
// - Write-one and read-start low pulses last 1 to 15 us, as short as can be.
// - Write-zero low lasts 60 to 120 us and each slot lasts 60 to 120 us.
// - All code and command bits travel least significant bit first.
// - The idle line is released high; only a reset leaves it low past 120 us.
module swid_master #(
    parameter [19:0] RESET_LOW_CYC =
        `SWID_RESET_LOW_DURATION_US * `SWID_CLK_MHZ,
    parameter [19:0] RESET_HIGH_CYC =
        `SWID_RESET_HIGH_DURATION_US * `SWID_CLK_MHZ,
    parameter [19:0] PRESENCE_CYC =
        `SWID_PRESENCE_SAMPLE_US * `SWID_CLK_MHZ,
    parameter [19:0] SLOT_CYC =
        `SWID_SLOT_DURATION_US * `SWID_CLK_MHZ,
    parameter [19:0] LOW0_CYC =
        `SWID_WRITE_ZERO_LOW_DURATION_US * `SWID_CLK_MHZ
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       ce,
    input  wire       cmd_valid,
    output reg        cmd_ready,
    input  wire [1:0] cmd_op,
    input  wire [7:0] cmd_data,
    output reg        busy,
    output reg        presence,
    output reg        presence_done,
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    input  wire       rd_ready,
    output reg  [7:0] crc,
    output reg        crc_ok,
    input  wire       line_in,
    output reg        line_out,
    output reg        line_oe
);
    // Short counts derived from the timebase
    localparam [19:0] LOW1_CYC   = `SWID_WRITE_ONE_LOW_DURATION_US
                                   * `SWID_CLK_MHZ;
    localparam [19:0] SAMPLE_CYC = `SWID_READ_SAMPLE_US * `SWID_CLK_MHZ;
    localparam [19:0] REC_CYC    = `SWID_SLOT_RECOVERY_GAP_US
                                   * `SWID_CLK_MHZ;

    // States
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_RST_LOW  = 3'h1;
    localparam [2:0] ST_RST_HIGH = 3'h2;
    localparam [2:0] ST_SLOT_LOW = 3'h3;
    localparam [2:0] ST_SLOT_REL = 3'h4;
    localparam [2:0] ST_RECOV    = 3'h5;

    reg  [2:0]  state;
    reg  [19:0] cnt;
    reg  [1:0]  op;
    reg  [7:0]  shreg;
    reg  [2:0]  bitn;
    reg         fifo_push;
    reg         line_meta;
    reg         line_s;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [7:0]  fifo_dout;
    wire        fifo_out_ready;
    wire        crc_fb;
    wire [7:0]  next_crc;
    wire [19:0] low_len;

    ////////////////////////////////////////////////////////////////////////////
    // Line synchroniser, two stages
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_meta <= 1'b1;
            line_s    <= 1'b1;
        end else if (ce) begin
            line_meta <= line_in;
            line_s    <= line_meta;
        end
    end

    // Serial CRC step on the sampled bit
    assign crc_fb   = line_s ^ crc[0];
    assign next_crc = {1'b0, crc[7:1]} ^
                      (crc_fb ? `SWID_CRC_POLY : 8'h00);

    // Low phase: long for a zero write, short otherwise
    assign low_len = (op == `SWID_OP_WRITE && !shreg[0]) ? LOW0_CYC
                                                         : LOW1_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Bus sequencer
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= ST_IDLE;
            cnt           <= 20'h00000;
            op            <= `SWID_OP_RESET;
            shreg         <= 8'h00;
            bitn          <= 3'h0;
            fifo_push     <= 1'b0;
            cmd_ready     <= 1'b0;
            busy          <= 1'b0;
            presence      <= 1'b0;
            presence_done <= 1'b0;
            crc           <= `SWID_CRC_INIT;
            crc_ok        <= 1'b1;
            line_out      <= 1'b0;
            line_oe       <= 1'b0;
        end else if (ce) begin
            presence_done <= 1'b0;
            fifo_push     <= 1'b0;
            cnt           <= cnt + 20'h00001;
            case (state)
                ST_IDLE: begin
                    // Line released while idle
                    line_oe <= 1'b0;
                    cnt     <= 20'h00000;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op        <= cmd_op;
                        shreg     <= cmd_data;
                        bitn      <= 3'h0;
                        if (cmd_op == `SWID_OP_CRC_CLEAR) begin
                            crc    <= `SWID_CRC_INIT;
                            crc_ok <= 1'b1;
                        end else if (cmd_op == `SWID_OP_RESET) begin
                            busy    <= 1'b1;
                            crc     <= `SWID_CRC_INIT;
                            crc_ok  <= 1'b1;
                            line_oe <= 1'b1;
                            state   <= ST_RST_LOW;
                        end else begin
                            busy    <= 1'b1;
                            line_oe <= 1'b1;
                            state   <= ST_SLOT_LOW;
                        end
                    end else begin
                        busy      <= 1'b0;
                        cmd_ready <= fifo_in_ready & ~fifo_push;
                    end
                end
                ST_RST_LOW: begin
                    // Fixed low time, well under the upper bound
                    if (cnt == RESET_LOW_CYC - 20'h00001) begin
                        line_oe <= 1'b0;
                        cnt     <= 20'h00000;
                        state   <= ST_RST_HIGH;
                    end
                end
                ST_RST_HIGH: begin
                    if (cnt == PRESENCE_CYC)
                        presence <= ~line_s;
                    // No traffic until the high time has run out
                    if (cnt == RESET_HIGH_CYC - 20'h00001) begin
                        presence_done <= 1'b1;
                        state         <= ST_IDLE;
                    end
                end
                ST_SLOT_LOW: begin
                    if (cnt == low_len - 20'h00001) begin
                        line_oe <= 1'b0;
                        state   <= ST_SLOT_REL;
                    end
                end
                ST_SLOT_REL: begin
                    // Late sample inside the valid window
                    if (op == `SWID_OP_READ && cnt == SAMPLE_CYC) begin
                        shreg  <= {line_s, shreg[7:1]};
                        crc    <= next_crc;
                        crc_ok <= (next_crc == 8'h00);
                    end
                    if (cnt == SLOT_CYC - 20'h00001) begin
                        cnt   <= 20'h00000;
                        state <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    // Released gap before the next falling edge
                    if (cnt == REC_CYC - 20'h00001) begin
                        cnt <= 20'h00000;
                        if (op == `SWID_OP_WRITE)
                            shreg <= {1'b0, shreg[7:1]};
                        if (bitn == 3'h7) begin
                            fifo_push <= (op == `SWID_OP_READ);
                            state     <= ST_IDLE;
                        end else begin
                            bitn    <= bitn + 3'h1;
                            line_oe <= 1'b1;
                            state   <= ST_SLOT_LOW;
                        end
                    end
                end
                default: begin
                    line_oe <= 1'b0;
                    state   <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read bytes queue up for the user
    swid_fifo #(
        .W  (`SWID_FIFO_WIDTH),
        .D  (`SWID_FIFO_DEPTH),
        .AW (`SWID_FIFO_ADDR)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (shreg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_dout)
    );

    assign fifo_out_ready = ~rd_valid | rd_ready;

    // Registered output stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else if (ce && fifo_out_ready) begin
            rd_valid <= fifo_out_valid;
            if (fifo_out_valid)
                rd_data <= fifo_dout;
        end
    end
endmodule // swid_master

`default_nettype wire

/* verilog/swid_regs.vh */
`ifndef SWID_REGS_VH
`define SWID_REGS_VH

// Local timebase
`define SWID_CLK_MHZ                    250

// Line timing in microseconds
`define SWID_RESET_LOW_DURATION_US      480
`define SWID_RESET_LOW_LIMIT_US         960
`define SWID_RESET_HIGH_DURATION_US     480
`define SWID_PRESENCE_SAMPLE_US         70
`define SWID_SLOT_DURATION_US           70
`define SWID_WRITE_ZERO_LOW_DURATION_US 60
`define SWID_WRITE_ONE_LOW_DURATION_US  1
`define SWID_READ_SAMPLE_US             14
`define SWID_READ_VALID_WINDOW_US       15
`define SWID_SLOT_RECOVERY_GAP_US       1

// Command codes
`define SWID_OP_RESET                   2'h0
`define SWID_OP_WRITE                   2'h1
`define SWID_OP_READ                    2'h2
`define SWID_OP_CRC_CLEAR               2'h3

// CRC: x^8 + x^5 + x^4 + 1, reflected for LSB-first shifting
`define SWID_CRC_POLY                   8'h8C
`define SWID_CRC_INIT                   8'h00

// Read buffer shape
`define SWID_FIFO_WIDTH                 8
`define SWID_FIFO_DEPTH                 8
`define SWID_FIFO_ADDR                  3

`endif
